// ### design/clock_output_config_ctrl.sv
/*
 Output configuration block: APB registers holding format, amplitude,
 enable, channel power-down, reference mux and delay settings, plus
 decode of those settings into per-output controls.
 Assumes an APB master on pclk and a sysref sequencer driving
 sysref_pulse_active from the same clock domain.
*/
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "outcfg_params.svh"
module clock_output_config_ctrl (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [11:0]                paddr,
   input  wire logic [31:0]                pwdata,
   output logic [31:0]                     prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       sysref_pulse_active,
   output logic [4:0]                      clock_output,
   output logic [4:0]                      clk_buf_power_up,
   output logic [4:0]                      format_select,
   output outcfg_pkg::amp_t [4:0]          clk_amp_level,
   output logic [2:0]                      chan_power_up,
   output logic [17:0]                     chan_coarse_delay,
   output logic [3:0]                      reference_output,
   output outcfg_pkg::amp_t [3:0]          ref_amp_level,
   output outcfg_pkg::ref_state_t [3:0]    ref_state,
   output logic [3:0]                      ref_buf_power_up,
   output logic [3:0]                      ref_fine_power_up,
   output logic [3:0]                      ref_uses_sysref,
   output logic [7:0]                      ref_divider_sel,
   output logic [35:0]                     ref_delay
);
   import outcfg_pkg::*;

   // ************************************************************
   // Registers
   // ************************************************************
   logic [31:0] clk_cfg_r;
   logic [31:0] ref_cfg_r;
   logic [31:0] chan_cfg_r;
   logic [31:0] sr_ctrl_r;
   logic [31:0] ref_dly_r;
   logic [31:0] prdata_r;
   logic        pslverr_r;
   logic        sr_sync1_r;
   logic        sr_sync2_r;

   // ************************************************************
   // Bus decode
   // ************************************************************
   wire logic        access;
   wire logic        wr;
   wire logic        sel_clk;
   wire logic        sel_ref;
   wire logic        sel_chan;
   wire logic        sel_sr;
   wire logic        sel_stat;
   wire logic        sel_dly;
   wire logic        mapped;
   wire logic [31:0] status_word;
   logic      [31:0] rd_nxt;

   // Zero-wait slave: every access phase completes at once
   assign pready   = 1'b1;
   assign access   = psel && penable;
   assign wr       = access && pwrite;
   assign sel_clk  = (paddr == `OFF_CLK_CFG);
   assign sel_ref  = (paddr == `OFF_REF_CFG);
   assign sel_chan = (paddr == `OFF_CHAN_CFG);
   assign sel_sr   = (paddr == `OFF_SYSREF_CTRL);
   assign sel_stat = (paddr == `OFF_STATUS);
   assign sel_dly  = (paddr == `OFF_REF_DELAY);
   assign mapped   = sel_clk || sel_ref || sel_chan || sel_sr || sel_stat || sel_dly;
   assign prdata   = prdata_r;
   assign pslverr  = pslverr_r;

   // Read mux, if/else-if over the address
   always_comb begin
      if (sel_clk) begin
         rd_nxt = {12'h000, clk_cfg_r[19:0]};
      end else if (sel_ref) begin
         rd_nxt = ref_cfg_r;
      end else if (sel_chan) begin
         rd_nxt = chan_cfg_r;
      end else if (sel_sr) begin
         rd_nxt = {30'h0000_0000, sr_ctrl_r[1:0]};
      end else if (sel_stat) begin
         rd_nxt = status_word;
      end else if (sel_dly) begin
         rd_nxt = ref_dly_r;
      end else begin
         rd_nxt = 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_cfg_r  <= `CLK_CFG_RST;
         ref_cfg_r  <= `REF_CFG_RST;
         chan_cfg_r <= `CHAN_CFG_RST;
         sr_ctrl_r  <= `SR_CTRL_RST;
         ref_dly_r  <= `REF_DLY_RST;
      end else if (wr) begin
         if (sel_clk) clk_cfg_r <= pwdata;
         if (sel_ref) ref_cfg_r <= pwdata;
         if (sel_chan) chan_cfg_r <= pwdata;
         if (sel_sr) sr_ctrl_r <= pwdata;
         if (sel_dly) ref_dly_r <= pwdata;
      end
   end

   // Read data and error load at the setup edge, so they already stand
   // through the access phase, when the master takes them with pready high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r  <= (psel && !penable && !pwrite) ? rd_nxt : prdata_r;
         pslverr_r <= psel && !penable && !mapped;
      end
   end

   // Pulse-active level comes from the sequencer; synchronised for safety
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr_sync1_r <= 1'b0;
         sr_sync2_r <= 1'b0;
      end else begin
         sr_sync1_r <= sysref_pulse_active;
         sr_sync2_r <= sr_sync1_r;
      end
   end

   // ************************************************************
   // Sysref automatic power control
   // ************************************************************
   wire logic continuous_mode;
   wire logic pulses_on;
   wire logic ref_auto_pd;
   assign continuous_mode = sr_ctrl_r[`SR_CONT_BIT];
   // Software pulse request or sequencer activity both count as active
   assign pulses_on = sr_ctrl_r[`SR_ACTIVE_BIT] || sr_sync2_r;
   // counted mode idle powers sysref-mode references down
   assign ref_auto_pd = !continuous_mode && !pulses_on;

   // ************************************************************
   // Channel power and coarse delay
   // ************************************************************
   genvar k;
   generate
      for (k = 0; k < `N_CHAN; k++) begin : g_chan
         assign chan_power_up[k] = !chan_cfg_r[`CH_PD_LO + k];
         assign chan_coarse_delay[6*k +: 6] =
            chan_cfg_r[`CH_DLY_LO + `CH_DLY_STRIDE*k +: `COARSE_W];
      end
   endgenerate

   // ************************************************************
   // Clock outputs: A0 A1 B0 B1 C
   // ************************************************************
   // Bank of clock output index, shared by decode below
   function automatic logic [1:0] clk_bank(input int idx);
      clk_bank = (idx < 2) ? 2'd0 : (idx < 4) ? 2'd1 : 2'd2;
   endfunction

   genvar i;
   generate
      for (i = 0; i < `N_CLK; i++) begin : g_clk
         wire logic [3:0] fld;
         wire logic       amp_nz;
         assign fld = clk_cfg_r[`CLK_FLD_W*i +: `CLK_FLD_W];
         assign amp_nz = (fld[1:0] != 2'h0);
         // same amplitude decode for either format
         assign format_select[i]    = fld[`FLD_FMT];
         assign clk_buf_power_up[i] = amp_nz && chan_power_up[clk_bank(i)];
         assign clk_amp_level[i]    = clk_buf_power_up[i] && fld[`FLD_EN] ?
                                      amp_t'(fld[1:0]) : amp_off;
         assign clock_output[i] = fld[`FLD_EN] && clk_buf_power_up[i];
      end
   endgenerate

   // ************************************************************
   // Reference outputs: A0 A1 B0 B1
   // ************************************************************
   genvar j;
   generate
      for (j = 0; j < `N_REF; j++) begin : g_ref
         wire logic [7:0] fld;
         wire logic       drive;
         assign fld = ref_cfg_r[`REF_FLD_W*j +: `REF_FLD_W];
         // reference A uses bank A divider, B uses bank B
         assign ref_divider_sel[2*j +: 2] = (j < 2) ? 2'd0 : 2'd1;
         assign ref_uses_sysref[j] = fld[`FLD_SEL];
         ref_output_ctrl u_ref (
            .amp_code            (fld[1:0]),
            .output_enable_bit   (fld[`FLD_REN]),
            .ref_output_select   (fld[`FLD_SEL]),
            .fine_pd             (fld[`FLD_PD]),
            .auto_pd             (ref_auto_pd),
            // 8-step fine delay per reference output
            .fine_delay          (ref_dly_r[8*j +: `FINE_W]),
            .bank_delay          (chan_coarse_delay[6*(j/2) +: 6]),
            .amp_level           (ref_amp_level[j]),
            .ref_state           (ref_state[j]),
            .buf_power_up        (ref_buf_power_up[j]),
            .drive_active        (drive),
            .fine_delay_power_up (ref_fine_power_up[j]),
            .delay_out           (ref_delay[9*j +: 9])
         );
         assign reference_output[j] = drive;
      end
   endgenerate

   // Status shows live decoded state
   assign status_word = {5'h00, ref_buf_power_up, ref_fine_power_up,
                         1'b0, chan_power_up, ref_auto_pd, clk_buf_power_up,
                         clock_output, reference_output};

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   clk_en_low_a: assert property (!clk_cfg_r[`FLD_EN] |-> !clock_output[0])
      else $error("clock output 0 high while disabled");
   clk_amp_off_a: assert property ((clk_cfg_r[1:0] == 2'h0) |-> clk_amp_level[0] == amp_off)
      else $error("clock amplitude not off on code 00");
   clk_amp_map_a: assert property ((clk_cfg_r[3:0] == 4'hA) && chan_power_up[0]
                                   |-> clk_amp_level[0] == amp_700mv)
      else $error("clock amplitude 10 not 700mV");
   chan_pd_a: assert property (chan_cfg_r[`CH_PD_LO] |-> !chan_power_up[0])
      else $error("channel A powered while power-down set");
   ref_amp_zero_a: assert property ((ref_cfg_r[1:0] == 2'h0) |-> !ref_buf_power_up[0])
      else $error("reference buffer on with amplitude 00");
   ref_en_low_a: assert property (!ref_cfg_r[`FLD_REN] |-> !reference_output[0])
      else $error("reference output 0 high while disabled");
   ref_fine_pd_a: assert property (ref_cfg_r[`FLD_PD] |-> !ref_fine_power_up[0])
      else $error("fine delay powered while power-down set");
   auto_pd_a: assert property (ref_cfg_r[`FLD_SEL] && ref_auto_pd |-> !ref_buf_power_up[0])
      else $error("sysref output powered while idle in counted mode");
   auto_pu_a: assert property ($rose(sr_sync2_r) && !continuous_mode && ref_cfg_r[2:0] == 3'h5
                               |-> ref_buf_power_up[0])
      else $error("sysref output not powered for pulses");
   ref_delay_a: assert property (!ref_cfg_r[`FLD_SEL] |-> ref_delay[5:0]
                                 == chan_cfg_r[`CH_DLY_LO +: 6])
      else $error("clock-mode reference not using bank delay");
   hold_cfg_a: assert property (!(psel && penable && pwrite) |=> $stable(clk_cfg_r))
      else $error("configuration changed without a write");

   cov_sysref_c: cover property (ref_state[0] == ref_sysref);
   cov_clockref_c: cover property (ref_state[1] == ref_clock);
   cov_clk_1000_c: cover property (clk_amp_level[4] == amp_1000mv);
   cov_autopd_c: cover property (ref_auto_pd ##1 !ref_auto_pd);
endmodule
`default_nettype wire

// ### design/ref_output_ctrl.sv
/*
 Decoder for one reference output: mode, buffer power, level, delay source.
 Assumes configuration bits from registers on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ref_output_ctrl (
   input  wire logic [1:0]           amp_code,
   input  wire logic                 output_enable_bit,
   input  wire logic                 ref_output_select,
   input  wire logic                 fine_pd,
   input  wire logic                 auto_pd,
   input  wire logic [2:0]           fine_delay,
   input  wire logic [5:0]           bank_delay,
   output outcfg_pkg::amp_t          amp_level,
   output outcfg_pkg::ref_state_t    ref_state,
   output logic                      buf_power_up,
   output logic                      drive_active,
   output logic                      fine_delay_power_up,
   output logic [8:0]                delay_out
);
   import outcfg_pkg::*;

   // ************************************************************
   // Decode
   // ************************************************************
   wire logic amp_zero;
   wire logic sysref_mode;
   // Amplitude 00 switches the buffer off in either mode
   assign amp_zero    = (amp_code == 2'h0);
   assign sysref_mode = ref_output_select;
   // buffer off on 00, fine delay off on power-down bit
   // counted mode idle also takes the buffer off in sysref mode
   assign buf_power_up        = !amp_zero && !(sysref_mode && auto_pd);
   assign fine_delay_power_up = !fine_pd;
   // enable gates clock mode; enable gates sysref mode
   assign drive_active = buf_power_up && output_enable_bit;
   assign amp_level    = drive_active ? amp_t'(amp_code) : amp_off;
   // select bit picks clock or sysref behaviour
   assign ref_state = !buf_power_up ? ref_buf_off :
                      !output_enable_bit ? ref_low :
                      sysref_mode ? ref_sysref : ref_clock;
   // clock mode takes the bank coarse delay, sysref the fine stage
   assign delay_out = sysref_mode ? {6'h00, fine_delay} : {3'h0, bank_delay};
endmodule
`default_nettype wire

// ### shared/outcfg_params.svh
/*
 Offsets, field positions, sizes and reset values for the output
 configuration block. Assumes inclusion by bare name from design files.
*/
`ifndef OUTCFG_PARAMS_SVH
`define OUTCFG_PARAMS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFF_CLK_CFG      12'h000
`define OFF_REF_CFG      12'h004
`define OFF_CHAN_CFG     12'h008
`define OFF_SYSREF_CTRL  12'h00C
`define OFF_STATUS       12'h010
`define OFF_REF_DELAY    12'h014

// ************************************************************
// Field layout: clock output i uses bits [4*i+3:4*i]
// ************************************************************
`define CLK_FLD_W        4
`define FLD_AMP_LO       0
`define FLD_FMT          2
`define FLD_EN           3
// Reference output j uses bits [8*j+4:8*j]
`define REF_FLD_W        8
`define FLD_SEL          2
`define FLD_PD           4
`define FLD_REN          3
// Clock channel k: power-down bit k, coarse delay bits [8*k+13:8*k+8]
`define CH_PD_LO         0
`define CH_DLY_LO        8
`define CH_DLY_STRIDE    8
`define SR_CONT_BIT      0
`define SR_ACTIVE_BIT    1

// ************************************************************
// Sizes and reset values
// ************************************************************
`define N_CLK            5
`define N_REF            4
`define N_CHAN           3
`define COARSE_W         6
`define FINE_W           3
`define CLK_CFG_RST      32'h0000_0000
`define REF_CFG_RST      32'h0000_0000
`define CHAN_CFG_RST     32'h0000_0000
`define SR_CTRL_RST      32'h0000_0000
`define REF_DLY_RST      32'h0000_0000

`endif

// ### shared/outcfg_pkg.sv
/*
 Types shared by the output configuration block.
 Assumes nothing of its surroundings.
*/
package outcfg_pkg;
   // Decoded amplitude of one output buffer
   typedef enum logic [1:0] {
      amp_off,
      amp_400mv,
      amp_700mv,
      amp_1000mv
   } amp_t;

   // Operating state of one reference output
   typedef enum logic [1:0] {
      ref_buf_off,
      ref_low,
      ref_clock,
      ref_sysref
   } ref_state_t;
endpackage

// ### testbench/clock_output_config_ctrl_tb_top.sv
/*
 Self-checking bench for the output configuration block: APB register
 traffic, decoded output controls, auto power-down of reference outputs.
 Assumes the design answers with no wait states, as its hand-over states.
*/
`timescale 1ns/10ps
`default_nettype none
module clock_output_config_ctrl_tb_top;
   import outcfg_pkg::*;
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic             sysref_pulse_active, err;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata, rd, seed, rc, rr, rh, rdl, rs, tmp;
   logic [4:0]       clock_output, clk_buf_power_up, format_select;
   amp_t [4:0]       clk_amp_level;
   logic [2:0]       chan_power_up;
   logic [17:0]      chan_coarse_delay;
   logic [3:0]       reference_output, ref_buf_power_up, ref_fine_power_up, ref_uses_sysref;
   amp_t [3:0]       ref_amp_level;
   ref_state_t [3:0] ref_state;
   logic [7:0]       ref_divider_sel;
   logic [35:0]      ref_delay;
   int               num_errors, checks;

   clock_output_config_ctrl clock_output_config_ctrl_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sysref_pulse_active(sysref_pulse_active),
      .clock_output(clock_output), .clk_buf_power_up(clk_buf_power_up),
      .format_select(format_select), .clk_amp_level(clk_amp_level),
      .chan_power_up(chan_power_up), .chan_coarse_delay(chan_coarse_delay),
      .reference_output(reference_output), .ref_amp_level(ref_amp_level),
      .ref_state(ref_state), .ref_buf_power_up(ref_buf_power_up),
      .ref_fine_power_up(ref_fine_power_up), .ref_uses_sysref(ref_uses_sysref),
      .ref_divider_sel(ref_divider_sel), .ref_delay(ref_delay));

   // ************************************************************
   // Clock, random source, expectation functions
   // ************************************************************
   always #50 pclk = ~pclk;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Clock side: {out, buf, fmt, amp, chan up, coarse}
   function automatic logic [45:0] exp_clk(input logic [31:0] c, h);
      logic [45:0] v;
      logic [1:0]  a;
      logic        on;
      v = '0;
      for (int i = 0; i < 5; i++) begin
         a = c[4*i +: 2];
         on = !h[i/2];   // A0,A1 on A; B0,B1 on B; C alone
         v[41+i] = c[4*i+3] && a != 2'b00 && on;
         v[36+i] = a != 2'b00 && on;
         v[31+i] = c[4*i+2];
         v[21+2*i +: 2] = (c[4*i+3] && on) ? a : 2'b00;
      end
      for (int k = 0; k < 3; k++) begin
         v[18+k] = !h[k];
         v[6*k +: 6] = h[8*k+8 +: 6];
      end
      return v;
   endfunction

   // Reference side: {out, amp, state, buf, fine, sysref, div, delay}
   function automatic logic [75:0] exp_ref(input logic [31:0] r, h, d, s, input logic p);
      logic [75:0] v;
      logic [4:0]  f;
      logic        pu, apd;
      v = '0;
      apd = !s[0] && !(s[1] || p);   // Counted mode with no pulses
      for (int j = 0; j < 4; j++) begin
         f = r[8*j +: 5];
         pu = f[1:0] != 2'b00 && !(f[2] && apd);
         v[72+j] = pu && f[3];
         v[64+2*j +: 2] = (pu && f[3]) ? f[1:0] : 2'b00;
         v[56+2*j +: 2] = !pu ? 2'd0 : !f[3] ? 2'd1 : f[2] ? 2'd3 : 2'd2;
         v[52+j] = pu;
         v[48+j] = !f[4];
         v[44+j] = f[2];
         v[36+2*j +: 2] = 2'(j / 2);
         v[9*j +: 9] = f[2] ? {6'b0, d[8*j +: 3]} : {3'b0, h[8*(j/2)+8 +: 6]};
      end
      return v;
   endfunction

   // ************************************************************
   // Compare tasks and closing
   // ************************************************************
   task automatic check_word(input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t register read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_vec(input logic [127:0] got, exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t outputs %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      if (num_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ************************************************************
   // APB master: hold the request until pready is seen high
   // ************************************************************
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= w;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      // Answer taken at the edge where pready is seen high
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rb(input logic [11:0] a, input logic [31:0] w, m);
      apb(1'b0, a, 32'h0000_0000);
      check_word(rd & m, w & m);
      check_vec(err, 1'b0);
   endtask

   // Settle past the pulse synchroniser before looking at the decode
   task automatic check_outs();
      repeat (3) @(posedge pclk);
      #1;
      check_vec({clock_output, clk_buf_power_up, format_select, clk_amp_level,
                 chan_power_up, chan_coarse_delay}, exp_clk(rc, rh));
      check_vec({reference_output, ref_amp_level, ref_state, ref_buf_power_up,
                 ref_fine_power_up, ref_uses_sysref, ref_divider_sel, ref_delay},
                exp_ref(rr, rh, rdl, rs, sysref_pulse_active));
   endtask

   task automatic cfg(input logic [31:0] c, r, h, d, s);
      rc = c;
      rr = r;
      rh = h;
      rdl = d;
      rs = s;
      apb(1'b1, 12'h000, c);
      apb(1'b1, 12'h004, r);
      apb(1'b1, 12'h008, h);
      apb(1'b1, 12'h014, d);
      apb(1'b1, 12'h00C, s);
      check_outs();
   endtask

   // Status word: live decode placed as the register map has it
   function automatic logic [31:0] exp_stat(input logic [45:0] c, input logic [75:0] r,
                                            input logic apd);
      return {5'h00, r[55:52], r[51:48], 1'b0, c[20:18], apd, c[40:36], c[45:41], r[75:72]};
   endfunction

   task automatic read_all();
      rb(12'h000, rc, 32'hFFFF_FFFF & 32'h000F_FFFF);
      check_word({rd[31:20], 20'h0_0000}, 32'h0000_0000);
      rb(12'h010, exp_stat(exp_clk(rc, rh), exp_ref(rr, rh, rdl, rs, sysref_pulse_active),
                           !rs[0] && !(rs[1] || sysref_pulse_active)), 32'hFFFF_FFFF);
      rb(12'h004, rr, 32'h1F1F_1F1F);
      rb(12'h008, rh, 32'h3F3F_3F07);
      rb(12'h014, rdl, 32'h0707_0707);
      rb(12'h00C, rs, 32'h0000_0003);
   endtask

   // ************************************************************
   // Watchdog and main sequence
   // ************************************************************
   initial begin
      #2_000_000;
      num_errors++;
      end_of_test();
   end

   initial begin
      {pclk, presetn, psel, penable, pwrite, sysref_pulse_active} = '0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      {rc, rr, rh, rdl, rs} = '0;
      seed = 32'h0000_0024;
      num_errors = 0;
      checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      check_outs();
      read_all();
      // Every amplitude code, format, enable and channel power state
      for (int c = 0; c < 128; c++)
         cfg({12'h000, {5{c[3:0]}}}, rr, (xs() & 32'h3F3F_3F00) | c[6:4], rdl, 32'h0000_0001);
      // Reference mode, enable, amplitude and fine power against pulse modes
      for (int c = 0; c < 96; c++)
         cfg(rc, {4{3'b000, 5'(c)}}, rh, xs() & 32'h0707_0707, 32'(c / 32));
      // Sysref 400 mV enabled in counted mode: input pulses wake it after two edges
      // Unused refs 0,1 parked; clock-mode refs 2,3 with fine stage off
      cfg(rc, 32'h1B1B_1010, rh, rdl, 32'h0000_0000);
      cfg(rc, 32'h0D0D_0D0D, rh, rdl, 32'h0000_0000);
      @(posedge pclk);
      sysref_pulse_active <= 1'b1;
      @(posedge pclk);
      #1 check_vec(ref_buf_power_up, 4'h0);
      @(posedge pclk);
      #1 check_vec(ref_buf_power_up, 4'hF);
      @(posedge pclk);
      sysref_pulse_active <= 1'b0;
      check_outs();
      // Random configurations with read-back
      for (int i = 0; i < 40; i++) begin
         tmp = xs();
         @(posedge pclk);
         sysref_pulse_active <= tmp[0];
         cfg(xs(), xs(), xs(), xs(), xs());
         read_all();
      end
      // Unmapped address: write ignored, read zero, error flagged
      apb(1'b1, 12'h018, 32'hFFFF_FFFF);
      check_vec(err, 1'b1);
      apb(1'b0, 12'h018, 32'h0000_0000);
      check_vec(err, 1'b1);
      check_word(rd, 32'h0000_0000);
      read_all();
      // Reset in mid-run clears every setting
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      {rc, rr, rh, rdl, rs} = '0;
      check_outs();
      read_all();
      end_of_test();
   end
endmodule
`default_nettype wire
